// file: common/fapc_map.vh
/*
 Constants for the parallel flash command controller: register map,
 control fields, operation codes, command words and bus timing.
 Assumes a 25 MHz system clock and a flash in word mode.
*/
`ifndef FAPC_MAP_VH
`define FAPC_MAP_VH

// Software register byte addresses
`define FAPC_REG_CTRL 8'h00
`define FAPC_REG_ADDR 8'h04
`define FAPC_REG_DATA 8'h08
`define FAPC_REG_STAT 8'h0c
`define FAPC_REG_HV 8'h10

// Control register fields
`define FAPC_OP_LSB 0
`define FAPC_OP_MSB 2
`define FAPC_IDX_LSB 3
`define FAPC_IDX_MSB 4
`define FAPC_RECOV_BIT 5

// High-voltage register fields
`define FAPC_HV_UNPROT_BIT 0
`define FAPC_HV_ALLPROT_BIT 1
`define FAPC_HV_HWRST_BIT 2

// Operation codes
`define FAPC_OP_READ 3'h0
`define FAPC_OP_WRITE 3'h1
`define FAPC_OP_RESET 3'h2
`define FAPC_OP_AUTOSEL 3'h3
`define FAPC_OP_HVID 3'h4

// Step kinds of a sequence
`define FAPC_STEP_NONE 2'h0
`define FAPC_STEP_WR 2'h1
`define FAPC_STEP_RD 2'h2

// Command words, word mode
`define FAPC_UNLOCK1_ADDR 18'h00555
`define FAPC_UNLOCK1_DATA 16'h00aa
`define FAPC_UNLOCK2_ADDR 18'h002aa
`define FAPC_UNLOCK2_DATA 16'h0055
`define FAPC_AUTOSEL_DATA 16'h0090
`define FAPC_RESET_DATA 16'h00f0

// Address masks for identifier reads, and the timeout bit of read data
`define FAPC_HVID_MASK 18'h00043
`define FAPC_AS_LOW_MASK 18'h000ff
`define FAPC_TIMEOUT_BIT 5

// Timing in ns
`define FAPC_CLK_NS 40
`define FAPC_T_SETUP_NS 40
`define FAPC_T_WP_NS 35
`define FAPC_T_ACC_NS 70
`define FAPC_T_HOLD_NS 40
`define FAPC_T_HV_SETTLE_NS 500

`endif

// file: verilog/fapc_cycle.v
/*
 One flash bus cycle, read or write, on the flash control pins.
 Assumes the flash samples on its pin edges; all pins leave flip-flops.
*/
`timescale 1ns/1ps
module fapc_cycle
#(
   parameter AW = 18,
   parameter DW = 16,
   parameter SETUP_CYC = 1,
   parameter WP_CYC = 1,
   parameter RD_CYC = 2,
   parameter HOLD_CYC = 1
)
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Request
   input wire start,
   input wire wr,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   output reg done,
   output reg [DW-1:0] rdata,
   // Flash pins
   output reg [AW-1:0] fl_addr,
   output reg fl_ce_n,
   output reg fl_oe_n,
   output reg fl_we_n,
   output reg [DW-1:0] fl_dq_out,
   output reg fl_dq_oe,
   input wire [DW-1:0] fl_dq_in
);

localparam C_IDLE = 2'h0;
localparam C_SETUP = 2'h1;
localparam C_STROBE = 2'h2;
localparam C_HOLD = 2'h3;
localparam integer SETUP_M1 = SETUP_CYC - 1;
localparam integer WP_M1 = WP_CYC - 1;
localparam integer RD_M1 = RD_CYC - 1;
localparam integer HOLD_M1 = HOLD_CYC - 1;

reg [1:0] state_reg;
reg [7:0] cnt_reg;
reg wr_reg;

// Cycle sequencer: setup, strobe, hold
always @(posedge clk_sys)
begin
   if (!rst_n)
   begin
      state_reg <= C_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= {DW{1'b0}};
      fl_addr <= {AW{1'b0}};
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_dq_out <= {DW{1'b0}};
      fl_dq_oe <= 1'b0;
   end
   else
   begin
      done <= 1'b0;
      case (state_reg)
         C_IDLE:
         begin
            if (start)
            begin
               fl_addr <= addr;
               fl_ce_n <= 1'b0;
               fl_dq_out <= wdata;
               fl_dq_oe <= wr;
               wr_reg <= wr;
               cnt_reg <= SETUP_M1[7:0];
               state_reg <= C_SETUP;
            end
         end
         C_SETUP:
         begin
            if (cnt_reg == 8'h00)
            begin
               // Strobe falls last, so it latches the address
               fl_we_n <= ~wr_reg;
               fl_oe_n <= wr_reg;
               cnt_reg <= wr_reg ? WP_M1[7:0] : RD_M1[7:0];
               state_reg <= C_STROBE;
            end
            else
               cnt_reg <= cnt_reg - 8'h01;
         end
         C_STROBE:
         begin
            if (cnt_reg == 8'h00)
            begin
               // Strobe rises first, data still held
               fl_we_n <= 1'b1;
               fl_oe_n <= 1'b1;
               if (!wr_reg)
                  rdata <= fl_dq_in;
               cnt_reg <= HOLD_M1[7:0];
               state_reg <= C_HOLD;
            end
            else
               cnt_reg <= cnt_reg - 8'h01;
         end
         C_HOLD:
         begin
            if (cnt_reg == 8'h00)
            begin
               fl_ce_n <= 1'b1;
               fl_dq_oe <= 1'b0;
               done <= 1'b1;
               state_reg <= C_IDLE;
            end
            else
               cnt_reg <= cnt_reg - 8'h01;
         end
         default:
            state_reg <= C_IDLE;
      endcase
   end
end

endmodule

// file: verilog/fapc_ctrl.v
/*
 Host-side controller for a parallel flash: software registers, command
 sequences for reset and autoselect, high-voltage identifier reads,
 temporary unprotect request and supply-low write inhibit.
 Assumes pins are synchronous to clk_sys and the flash runs in word mode.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "fapc_map.vh"
module fapc_ctrl
#(
   parameter AW = 18,
   parameter DW = 16
)
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Software register port
   input wire [7:0] sw_addr,
   input wire [31:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   output reg [31:0] sw_rdata,
   // Flash bus
   output wire [AW-1:0] fl_addr,
   output wire fl_ce_n,
   output wire fl_oe_n,
   output wire fl_we_n,
   output wire [DW-1:0] fl_dq_out,
   output wire fl_dq_oe,
   input wire [DW-1:0] fl_dq_in,
   // High-voltage requests and hardware reset
   output reg id_hv_req,
   output reg clear_hv_req,
   output reg fl_rst_n,
   // Supply monitor
   input wire vcc_ok
);

localparam integer SETUP_RAW = (`FAPC_T_SETUP_NS + `FAPC_CLK_NS - 1) / `FAPC_CLK_NS;
localparam integer WP_RAW = (`FAPC_T_WP_NS + `FAPC_CLK_NS - 1) / `FAPC_CLK_NS;
localparam integer ACC_RAW = (`FAPC_T_ACC_NS + `FAPC_CLK_NS - 1) / `FAPC_CLK_NS;
localparam integer HOLD_RAW = (`FAPC_T_HOLD_NS + `FAPC_CLK_NS - 1) / `FAPC_CLK_NS;
localparam integer HV_RAW = (`FAPC_T_HV_SETTLE_NS + `FAPC_CLK_NS - 1) / `FAPC_CLK_NS;
localparam integer SETUP_CYC = (SETUP_RAW < 1) ? 1 : SETUP_RAW;
localparam integer WP_CYC = (WP_RAW < 1) ? 1 : WP_RAW;
localparam integer RD_CYC = ((ACC_RAW < 1) ? 1 : ACC_RAW) + 1;
localparam integer HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
localparam integer HV_M1 = ((HV_RAW < 1) ? 1 : HV_RAW) - 1;

localparam M_IDLE = 2'h0;
localparam M_SETTLE = 2'h1;
localparam M_ISSUE = 2'h2;
localparam M_WAIT = 2'h3;

reg [1:0] state_reg;
reg [2:0] op_reg;
reg [1:0] idx_reg;
reg recov_reg;
reg recov_hit_reg;
reg [2:0] step_reg;
reg [7:0] settle_reg;
reg busy_reg;
reg done_reg;
reg refused_reg;
reg timeout_reg;
reg [AW-1:0] addr_reg;
reg [DW-1:0] data_reg;
reg unprot_reg;
reg allprot_reg;
reg hwrst_reg;
reg cyc_start_reg;
reg cyc_wr_reg;
reg [AW-1:0] cyc_addr_reg;
reg [DW-1:0] cyc_wdata_reg;
reg [1:0] step_kind;
reg [AW-1:0] step_addr;
reg [DW-1:0] step_data;
wire cyc_done;
wire [DW-1:0] cyc_rdata;
wire [AW-1:0] idx_ext;
wire ctrl_wr;
wire start_ok;

assign idx_ext = {{(AW-2){1'b0}}, idx_reg};
assign ctrl_wr = sw_wr && (sw_addr == `FAPC_REG_CTRL);
// Supply low or busy refuses a new operation
assign start_ok = ctrl_wr && !busy_reg && vcc_ok;

// Bus cycle engine
fapc_cycle
#(
   .AW(AW),
   .DW(DW),
   .SETUP_CYC(SETUP_CYC),
   .WP_CYC(WP_CYC),
   .RD_CYC(RD_CYC),
   .HOLD_CYC(HOLD_CYC)
)
u_cycle
(
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .start(cyc_start_reg),
   .wr(cyc_wr_reg),
   .addr(cyc_addr_reg),
   .wdata(cyc_wdata_reg),
   .done(cyc_done),
   .rdata(cyc_rdata),
   .fl_addr(fl_addr),
   .fl_ce_n(fl_ce_n),
   .fl_oe_n(fl_oe_n),
   .fl_we_n(fl_we_n),
   .fl_dq_out(fl_dq_out),
   .fl_dq_oe(fl_dq_oe),
   .fl_dq_in(fl_dq_in)
);

// Step table: kind, address and data of each step of an operation
always @*
begin
   step_kind = `FAPC_STEP_NONE;
   step_addr = addr_reg;
   step_data = data_reg;
   case (op_reg)
      `FAPC_OP_READ:
      begin
         // Plain array read, no command before it
         if (step_reg == 3'h0)
            step_kind = `FAPC_STEP_RD;
         else if (step_reg == 3'h1 && recov_hit_reg)
         begin
            step_kind = `FAPC_STEP_WR;
            step_data = `FAPC_RESET_DATA;
         end
      end
      `FAPC_OP_WRITE:
      begin
         if (step_reg == 3'h0)
            step_kind = `FAPC_STEP_WR;
      end
      `FAPC_OP_RESET:
      begin
         if (step_reg == 3'h0)
         begin
            step_kind = `FAPC_STEP_WR;
            step_data = `FAPC_RESET_DATA;
         end
      end
      `FAPC_OP_AUTOSEL:
      begin
         // Unlock, command, one read, then leave with reset
         case (step_reg)
            3'h0:
            begin
               step_kind = `FAPC_STEP_WR;
               step_addr = `FAPC_UNLOCK1_ADDR;
               step_data = `FAPC_UNLOCK1_DATA;
            end
            3'h1:
            begin
               step_kind = `FAPC_STEP_WR;
               step_addr = `FAPC_UNLOCK2_ADDR;
               step_data = `FAPC_UNLOCK2_DATA;
            end
            3'h2:
            begin
               step_kind = `FAPC_STEP_WR;
               step_addr = `FAPC_UNLOCK1_ADDR;
               step_data = `FAPC_AUTOSEL_DATA;
            end
            3'h3:
            begin
               step_kind = `FAPC_STEP_RD;
               step_addr = (addr_reg & ~`FAPC_AS_LOW_MASK) | idx_ext;
            end
            3'h4:
            begin
               step_kind = `FAPC_STEP_WR;
               step_data = `FAPC_RESET_DATA;
            end
            default:
               step_kind = `FAPC_STEP_NONE;
         endcase
      end
      `FAPC_OP_HVID:
      begin
         // Sector on top bits, A6 low, A1:A0 pick the code
         if (step_reg == 3'h0)
         begin
            step_kind = `FAPC_STEP_RD;
            step_addr = (addr_reg & ~`FAPC_HVID_MASK) | idx_ext;
         end
      end
      default:
         step_kind = `FAPC_STEP_NONE;
   endcase
end

// Operation sequencer
always @(posedge clk_sys)
begin
   if (!rst_n)
   begin
      state_reg <= M_IDLE;
      op_reg <= `FAPC_OP_READ;
      idx_reg <= 2'h0;
      recov_reg <= 1'b0;
      recov_hit_reg <= 1'b0;
      step_reg <= 3'h0;
      settle_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      timeout_reg <= 1'b0;
      data_reg <= {DW{1'b0}};
      id_hv_req <= 1'b0;
      cyc_start_reg <= 1'b0;
      cyc_wr_reg <= 1'b0;
      cyc_addr_reg <= {AW{1'b0}};
      cyc_wdata_reg <= {DW{1'b0}};
   end
   else
   begin
      cyc_start_reg <= 1'b0;
      if (sw_wr && sw_addr == `FAPC_REG_DATA)
         data_reg <= sw_wdata[DW-1:0];
      if (sw_wr && sw_addr == `FAPC_REG_STAT)
      begin
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
         timeout_reg <= 1'b0;
      end
      if (ctrl_wr && !start_ok)
         refused_reg <= 1'b1;
      case (state_reg)
         M_IDLE:
         begin
            if (start_ok)
            begin
               op_reg <= sw_wdata[`FAPC_OP_MSB:`FAPC_OP_LSB];
               idx_reg <= sw_wdata[`FAPC_IDX_MSB:`FAPC_IDX_LSB];
               recov_reg <= sw_wdata[`FAPC_RECOV_BIT];
               recov_hit_reg <= 1'b0;
               step_reg <= 3'h0;
               busy_reg <= 1'b1;
               done_reg <= 1'b0;
               if (sw_wdata[`FAPC_OP_MSB:`FAPC_OP_LSB] == `FAPC_OP_HVID)
               begin
                  id_hv_req <= 1'b1;
                  settle_reg <= HV_M1[7:0];
                  state_reg <= M_SETTLE;
               end
               else
                  state_reg <= M_ISSUE;
            end
         end
         M_SETTLE:
         begin
            // Let the identifier voltage settle before reading
            if (settle_reg == 8'h00)
               state_reg <= M_ISSUE;
            else
               settle_reg <= settle_reg - 8'h01;
         end
         M_ISSUE:
         begin
            if (step_kind == `FAPC_STEP_NONE)
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
               id_hv_req <= 1'b0;
               state_reg <= M_IDLE;
            end
            else if (step_kind == `FAPC_STEP_WR && !vcc_ok)
            begin
               // Supply dropped: abandon the sequence
               busy_reg <= 1'b0;
               refused_reg <= 1'b1;
               id_hv_req <= 1'b0;
               state_reg <= M_IDLE;
            end
            else
            begin
               cyc_start_reg <= 1'b1;
               cyc_wr_reg <= (step_kind == `FAPC_STEP_WR);
               cyc_addr_reg <= step_addr;
               cyc_wdata_reg <= step_data;
               state_reg <= M_WAIT;
            end
         end
         M_WAIT:
         begin
            if (cyc_done)
            begin
               if (!cyc_wr_reg)
               begin
                  data_reg <= cyc_rdata;
                  // Timeout bit seen on a read: flag it; with recovery set, a plain read op queues a reset write
                  if (cyc_rdata[`FAPC_TIMEOUT_BIT])
                  begin
                     timeout_reg <= 1'b1;
                     recov_hit_reg <= recov_reg;
                  end
               end
               step_reg <= step_reg + 3'h1;
               state_reg <= M_ISSUE;
            end
         end
         default:
            state_reg <= M_IDLE;
      endcase
   end
end

// High-voltage control register; unprotect needs all-protected acknowledge
always @(posedge clk_sys)
begin
   if (!rst_n)
   begin
      addr_reg <= {AW{1'b0}};
      unprot_reg <= 1'b0;
      allprot_reg <= 1'b0;
      hwrst_reg <= 1'b0;
      clear_hv_req <= 1'b0;
      fl_rst_n <= 1'b0;
   end
   else
   begin
      if (sw_wr && sw_addr == `FAPC_REG_ADDR && !busy_reg)
         addr_reg <= sw_wdata[AW-1:0];
      if (sw_wr && sw_addr == `FAPC_REG_HV)
      begin
         unprot_reg <= sw_wdata[`FAPC_HV_UNPROT_BIT];
         allprot_reg <= sw_wdata[`FAPC_HV_ALLPROT_BIT];
         hwrst_reg <= sw_wdata[`FAPC_HV_HWRST_BIT];
      end
      clear_hv_req <= unprot_reg && allprot_reg && !hwrst_reg;
      fl_rst_n <= !hwrst_reg && vcc_ok;
   end
end

// Register read port, data one cycle after the strobe
always @(posedge clk_sys)
begin
   if (!rst_n)
      sw_rdata <= 32'h00000000;
   else if (sw_rd)
   begin
      case (sw_addr)
         `FAPC_REG_CTRL:
            sw_rdata <= {26'h0000000, recov_reg, idx_reg, op_reg};
         `FAPC_REG_ADDR:
            sw_rdata <= {{(32-AW){1'b0}}, addr_reg};
         `FAPC_REG_DATA:
            sw_rdata <= {{(32-DW){1'b0}}, data_reg};
         `FAPC_REG_STAT:
            sw_rdata <= {27'h0000000, vcc_ok, timeout_reg, refused_reg, done_reg, busy_reg};
         `FAPC_REG_HV:
            sw_rdata <= {28'h0000000, clear_hv_req, hwrst_reg, allprot_reg, unprot_reg};
         default:
            sw_rdata <= 32'h00000000;
      endcase
   end
   else
      sw_rdata <= 32'h00000000;
end

endmodule

// file: testbench/fapc_ctrl_asserts.sv
/*
 Checker for the flash controller pins and register port.
 Assumes it is bound into fapc_ctrl and sees one clock domain.
*/
`timescale 1ns/1ps
module fapc_chk
#(
   parameter AW = 18,
   parameter DW = 16
)
(
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Register port
   input wire [7:0] sw_addr,
   input wire [31:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   input wire [31:0] sw_rdata,
   // Flash pins
   input wire [AW-1:0] fl_addr,
   input wire fl_ce_n,
   input wire fl_oe_n,
   input wire fl_we_n,
   input wire [DW-1:0] fl_dq_out,
   input wire fl_dq_oe,
   input wire [DW-1:0] fl_dq_in,
   input wire id_hv_req,
   input wire clear_hv_req,
   input wire fl_rst_n,
   input wire vcc_ok
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Requested unprotect needs acknowledge and no hold
   wire hv_want = sw_wdata[0] && sw_wdata[1] && !sw_wdata[2];
   // Tail of a write pulse and of a read strobe
   sequence s_wr_tail;
      (fl_we_n && !fl_ce_n) ##1 (fl_ce_n && !fl_dq_oe);
   endsequence
   sequence s_rd_tail;
      (!fl_oe_n) [*3] ##1 (fl_oe_n && !fl_ce_n) ##1 fl_ce_n;
   endsequence
   a_idle_after_rst: assert property ($rose(rst_n) |-> fl_ce_n && fl_we_n && fl_oe_n && !id_hv_req)
      else $error("flash pins not idle after reset");
   a_write_gate: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
      else $error("write strobe outside select");
   a_read_gate: assert property (!fl_oe_n |-> fl_we_n && !fl_ce_n && !fl_dq_oe)
      else $error("output enable during write");
   a_write_walk: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n) ##1 s_wr_tail)
      else $error("write cycle shape wrong");
   a_read_walk: assert property ($fell(fl_oe_n) |-> s_rd_tail)
      else $error("read cycle shape wrong");
   a_addr_hold: assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr) && $stable(fl_dq_out))
      else $error("address or data moved in cycle");
   a_rdata_slot: assert property (sw_rdata != 32'h0 |-> $past(sw_rd))
      else $error("read data outside its slot");
   a_low_vcc: assert property ((!vcc_ok) [*4] |-> fl_we_n)
      else $error("write pulse with low supply");
   a_clear_req: assert property (sw_wr && sw_addr == 8'h10 |-> ##2 clear_hv_req == $past(hv_want, 2))
      else $error("unprotect request wrong");
   a_hvid_settle: assert property ($rose(id_hv_req) |-> fl_ce_n [*8] ##[6:12] $fell(fl_ce_n))
      else $error("identifier read before settle");
endmodule

// file: testbench/fapc_flash_model.sv
/*
 Behavioural flash at the far side of the controller pins.
 Assumes word mode, a 16-word array and no program or erase.
*/
`timescale 1ns/1ps
module fapc_flash_model
#(
   parameter AW = 18,
   parameter DW = 16,
   parameter MAKER_ID = 16'h005a, // Arbitrary value
   parameter PART_ID = 16'h00c3 // Arbitrary value
)
(
   // Flash pins
   input wire [AW-1:0] fl_addr,
   input wire fl_ce_n,
   input wire fl_oe_n,
   input wire fl_we_n,
   input wire [DW-1:0] fl_dq_out,
   input wire fl_dq_oe,
   output wire [DW-1:0] fl_dq_in,
   // Voltage requests, reset, supply, access speed
   input wire id_hv_req,
   input wire clear_hv_req,
   input wire fl_rst_n,
   input wire vcc_ok,
   input wire slow
);
   reg [DW-1:0] mem [0:15];
   reg [7:0] prot_reg = 8'h00;
   reg [1:0] step_reg = 2'h0;
   reg asel_reg = 1'b0;
   reg armed = 1'b0;
   reg en_d = 1'b0;
   reg [AW-1:0] lat_addr;
   realtime t_fall;
   integer resets = 0;
   wire en = !fl_ce_n && !fl_oe_n && fl_rst_n;
   wire [DW-1:0] rv;
   // Identifier or protection word, zero for other offsets
   function [DW-1:0] idv(input [7:0] a);
      case (a)
         8'h00: idv = MAKER_ID;
         8'h01: idv = PART_ID;
         8'h02: idv = {{(DW-1){1'b0}}, prot_reg[fl_addr[AW-1:AW-3]]};
         default: idv = {DW{1'b0}};
      endcase
   endfunction
   // Command decode of one accepted write
   task take(input [DW-1:0] d);
      begin
         armed = 1'b0;
         if (d[7:0] == 8'hf0)
            resets = resets + 1;
         if (d[7:0] == 8'hf0)
            {step_reg, asel_reg} = 3'h0;
         else if (step_reg == 2'h0 && lat_addr[10:0] == 11'h555 && d[7:0] == 8'haa)
            step_reg = 2'h1;
         else if (step_reg == 2'h1 && lat_addr[10:0] == 11'h2aa && d[7:0] == 8'h55)
            step_reg = 2'h2;
         else if (step_reg == 2'h2 && lat_addr[10:0] == 11'h555 && d[7:0] == 8'h90)
            {step_reg, asel_reg} = 3'h1;
         else
         begin
            // Plain data write: lands only in a writable sector
            if (step_reg == 2'h0 && !asel_reg && (!prot_reg[lat_addr[AW-1:AW-3]] || clear_hv_req))
               mem[lat_addr[3:0]] = d;
            {step_reg, asel_reg} = 3'h0;
         end
      end
   endtask
   // Address on the later falling edge
   always @(negedge fl_we_n or negedge fl_ce_n)
      if (!fl_we_n && !fl_ce_n)
      begin
         lat_addr = fl_addr;
         t_fall = $realtime;
         armed = 1'b1;
      end
   // Data on the first rising edge, inhibits applied
   always @(posedge fl_we_n or posedge fl_ce_n)
      if (armed && (fl_we_n ^ fl_ce_n) && fl_oe_n && vcc_ok && fl_rst_n && $realtime - t_fall > 5.0)
         take(fl_dq_oe ? fl_dq_out : ~fl_dq_out);
   // Low supply or reset pin returns to reading array
   always @(negedge vcc_ok or negedge fl_rst_n)
      {step_reg, asel_reg} = 3'h0;
   assign rv = (id_hv_req && !fl_addr[6]) ? idv({6'h0, fl_addr[1:0]}) :
      asel_reg ? idv(fl_addr[7:0]) : mem[fl_addr[3:0]];
   // Access delay; outside a read the pins show the inverse
   always @(en)
      en_d <= #(slow ? 100 : 20) en;
   assign fl_dq_in = (en && en_d) ? rv : ~rv;
endmodule

// file: testbench/tb.sv
/*
 Top testbench: controller against the flash model.
 Assumes the checker and model files are compiled first.
*/
`timescale 1ns/1ps
`include "fapc_map.vh"
module tb;
   localparam [15:0] MK = 16'h005a;
   localparam [15:0] PT = 16'h00c3;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] sw_addr = 8'h00;
   reg [31:0] sw_wdata = 32'h0;
   reg sw_wr = 1'b0;
   reg sw_rd = 1'b0;
   reg vcc_ok = 1'b1;
   reg slow = 1'b0;
   wire [31:0] sw_rdata;
   wire [17:0] fl_addr;
   wire [15:0] fl_dq_out, fl_dq_in;
   wire fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, id_hv_req, clear_hv_req, fl_rst_n;
   integer fail_count = 0;
   integer n_compared = 0;
   integer i, s, k, n0;
   reg [31:0] rd;
   reg [39:0] rows [0:6];
   // Design and flash
   fapc_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
      .fl_dq_in(fl_dq_in), .id_hv_req(id_hv_req), .clear_hv_req(clear_hv_req), .fl_rst_n(fl_rst_n),
      .vcc_ok(vcc_ok));
   fapc_flash_model #(.MAKER_ID(MK), .PART_ID(PT)) flash (.fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
      .fl_dq_in(fl_dq_in), .id_hv_req(id_hv_req), .clear_hv_req(clear_hv_req), .fl_rst_n(fl_rst_n),
      .vcc_ok(vcc_ok), .slow(slow));
   // Clock
   always #20 clk_sys = ~clk_sys;
   // Register port cycles
   task sw_write(input [7:0] a, input [31:0] d);
      begin
         sw_addr <= a;
         sw_wdata <= d;
         sw_wr <= 1'b1;
         @(posedge clk_sys);
         sw_wr <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task sw_read(input [7:0] a, output [31:0] d);
      begin
         sw_addr <= a;
         sw_rd <= 1'b1;
         @(posedge clk_sys);
         sw_rd <= 1'b0;
         #1 d = sw_rdata;
         @(posedge clk_sys);
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp)
         begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("compared %0d, mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // One operation: clear status, start, wait, fetch data
   task run_op(input [17:0] a, input [5:0] c, output [31:0] d);
      begin
         sw_write(`FAPC_REG_STAT, 32'h0);
         sw_write(`FAPC_REG_ADDR, {14'h0, a});
         sw_write(`FAPC_REG_CTRL, {26'h0, c});
         k = 0;
         rd = 32'h0;
         while (rd[1] !== 1'b1 && rd[2] !== 1'b1 && k < 200)
         begin
            sw_read(`FAPC_REG_STAT, rd);
            k = k + 1;
         end
         if (rd[1] !== 1'b1 && rd[2] !== 1'b1)
         begin
            fail_count = fail_count + 1;
            test_done;
         end
         else
            sw_read(`FAPC_REG_DATA, d);
      end
   endtask
   // Main sequence
   initial
   begin
      for (k = 0; k < 16; k = k + 1)
         flash.mem[k] = 16'h1000 + k;
      flash.mem[7] = 16'h0027;
      rows[0] = {18'h00003, 6'h00, 16'h1003};
      rows[1] = {18'h00000, 6'h03, MK};
      rows[2] = {18'h00000, 6'h0b, PT};
      rows[3] = {18'h28000, 6'h13, 16'h0000};
      rows[4] = {18'h00040, 6'h04, MK};
      rows[5] = {18'h00000, 6'h0c, PT};
      rows[6] = {18'h00005, 6'h00, 16'h1005};
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (s = 0; s < 2; s = s + 1)
      begin
         slow <= s[0];
         for (i = 0; i < 7; i = i + 1)
         begin
            run_op(rows[i][39:22], rows[i][21:16], rd);
            check(rd, {16'h0, rows[i][15:0]});
         end
      end
      $display("table done");
      flash.prot_reg[5] = 1'b1;
      run_op(18'h28000, 6'h13, rd);
      check(rd, 32'h1);
      run_op(18'h28040, 6'h14, rd);
      check(rd, 32'h1);
      sw_write(`FAPC_REG_DATA, 32'h4444);
      run_op(18'h00009, 6'h01, rd);
      run_op(18'h00009, 6'h00, rd);
      check(rd, 32'h4444);
      sw_write(`FAPC_REG_DATA, 32'h0c0c);
      run_op(18'h28009, 6'h01, rd);
      run_op(18'h28009, 6'h00, rd);
      check(rd, 32'h4444);
      sw_write(`FAPC_REG_HV, 32'h3);
      sw_write(`FAPC_REG_DATA, 32'h0c0c);
      run_op(18'h28009, 6'h01, rd);
      sw_write(`FAPC_REG_HV, 32'h0);
      run_op(18'h28009, 6'h00, rd);
      check(rd, 32'h0c0c);
      $display("protection done");
      n0 = flash.resets;
      run_op(18'h00007, 6'h20, rd);
      check(rd, 32'h27);
      sw_read(`FAPC_REG_STAT, rd);
      check({31'h0, rd[3]}, 32'h1);
      check(flash.resets - n0, 32'h1);
      run_op(18'h3ffff, 6'h02, rd);
      check(flash.resets - n0, 32'h2);
      $display("timeout recovery done");
      vcc_ok <= 1'b0;
      run_op(18'h00000, 6'h02, rd);
      sw_read(`FAPC_REG_STAT, rd);
      check({30'h0, rd[4], rd[2]}, 32'h1);
      vcc_ok <= 1'b1;
      repeat (3) @(posedge clk_sys);
      $display("low supply done");
      sw_write(`FAPC_REG_HV, 32'h3);
      #1 check({30'h0, fl_rst_n, clear_hv_req}, 32'h3);
      @(posedge clk_sys);
      sw_write(`FAPC_REG_HV, 32'h1);
      #1 check({30'h0, fl_rst_n, clear_hv_req}, 32'h2);
      @(posedge clk_sys);
      sw_write(`FAPC_REG_HV, 32'h7);
      #1 check({30'h0, fl_rst_n, clear_hv_req}, 32'h0);
      @(posedge clk_sys);
      sw_write(`FAPC_REG_HV, 32'h0);
      sw_read(8'h14, rd);
      check(rd, 32'h0);
      $display("pins and unmapped done");
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      sw_read(`FAPC_REG_STAT, rd);
      check(rd, 32'h10);
      run_op(18'h00003, 6'h00, rd);
      check(rd, 32'h1003);
      $display("second reset done");
      test_done;
   end
endmodule
bind fapc_ctrl fapc_chk #(.AW(AW), .DW(DW)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
   .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
   .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .id_hv_req(id_hv_req),
   .clear_hv_req(clear_hv_req), .fl_rst_n(fl_rst_n), .vcc_ok(vcc_ok));
